/* File: shared/decoder_regs_pkg.sv */
// Constants for the decoder power, status and clamp register bank
package decoder_regs_pkg;

    // Bus geometry
    localparam int          ADDR_W        = 8;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_DECERR   = 2'h3;

    // Register indices; byte address is four times the index
    localparam logic [5:0]  IDX_POWER     = 6'h0f;
    localparam logic [5:0]  IDX_STATUS    = 6'h10;
    localparam logic [5:0]  IDX_REVISION  = 6'h11;
    localparam logic [5:0]  IDX_ANALOG    = 6'h13;
    localparam logic [5:0]  IDX_CLAMP     = 6'h14;
    localparam logic [5:0]  IDX_IRQ_STAT  = 6'h18;
    localparam logic [5:0]  IDX_IRQ_MASK  = 6'h19;

    // Reset values
    localparam logic [7:0]  POWER_RST     = 8'h00;
    localparam logic [7:0]  ANALOG_RST    = 8'h45;
    localparam logic [5:0]  CLAMP_RST     = 6'h00;
    localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;

    // Power register fields
    localparam int PWR_SAVE_LSB = 0;
    localparam int PWR_PRIO     = 2;
    localparam int PWR_REF      = 3;
    localparam int PWR_CG       = 4;
    localparam int PWR_OFF      = 5;
    localparam int PWR_REACQ    = 6;
    localparam int PWR_RESET    = 7;

    // Power save selection codes
    localparam logic [1:0]  SEL_FULL      = 2'h0;
    localparam logic [1:0]  SEL_COMPOSITE = 2'h1;
    localparam logic [1:0]  SEL_DIGITAL   = 2'h2;
    localparam logic [1:0]  SEL_SAVE      = 2'h3;

    // Status register fields
    localparam int ST_LOCK      = 0;
    localparam int ST_LOST      = 1;
    localparam int ST_FSC       = 2;
    localparam int ST_50HZ      = 3;
    localparam int ST_UNDER     = 4;
    localparam int ST_OVER      = 5;
    localparam int ST_WHITE     = 6;
    localparam int ST_KILL      = 7;

    // Analog control and clamp control fields
    localparam int AN_FORCE     = 1;
    localparam int CL_SLOW_LSB  = 0;
    localparam int CL_FAST_LSB  = 2;
    localparam int CL_CURR      = 4;
    localparam int CL_VOLT      = 5;

    // Interrupt status and mask fields
    localparam int IRQ_LOST     = 0;
    localparam int IRQ_GAIN     = 1;
    localparam int IRQ_UNDER    = 2;
    localparam int IRQ_OVER     = 3;

    // Timing: reference tick derived from the system clock
    localparam int          CLK_FREQ_KHZ  = 200000;
    localparam int          REF_FREQ_KHZ  = 27000;
    localparam logic [8:0]  ACC_MOD       = 9'(CLK_FREQ_KHZ / 1000);
    localparam logic [8:0]  REF_STEP      = 9'(REF_FREQ_KHZ / 1000);
    localparam logic [7:0]  CLAMP_BASE    = 8'h10;

endpackage

/* File: design/decoder_power_status_clamp_regs.sv */
// Power, status, revision and clamp register bank with AXI4-Lite access
// Function
// - Power save field bits 1:0 selects full, composite-only, digital-only or save mode
// - Power bit 2 picks pin (0) or register bit (1) as core power-down source
// - Power bit 3 puts the analog reference into power save
// - Power bit 4 puts the line-locked clock generator into power save
// - Power bit 5 disables input pads and stops the 27 MHz clock
// - Writing power bit 6 reacquires video, same as the reacquire pin
// - The reacquire bit clears itself on the next 27 MHz cycle
// - Writing power bit 7 resets core and register settings, then clears itself; bus handshake state is kept
// - Status shows lock, subcarrier lock, ADC under/overflow, white peak, color kill
// - Status bit 1 holds any loss of lock since the last status read
// - Status bit 3 reads 1 when a 50 Hz field rate is detected
// - A read-only eight-bit register returns the silicon revision code
// - Analog bit 1 forces sync drivers on, else OE pin and disable bit decide
// - Slow clamp current stays on 16, 32, 64 or 128 cycles per code
// - Fast clamp current stays on 16, 32, 64 or 128 cycles per code
// - Clamp bit 4 enables the front-end clamp current sources
// - Clamp bit 5 enables the voltage clamp circuitry
`timescale 1ns/1ps

module decoder_power_status_clamp_regs #(
    parameter logic [7:0] REVISION = 8'h2a  // Arbitrary value
) (
    input  wire logic                                aclk,
    input  wire logic                                aresetn,
    input  wire logic                                awvalid,
    output logic                                     awready,
    input  wire logic [decoder_regs_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                                wvalid,
    output logic                                     wready,
    input  wire logic [31:0]                         wdata,
    input  wire logic [3:0]                          wstrb,
    output logic                                     bvalid,
    input  wire logic                                bready,
    output logic [1:0]                               bresp,
    input  wire logic                                arvalid,
    output logic                                     arready,
    input  wire logic [decoder_regs_pkg::ADDR_W-1:0] araddr,
    output logic                                     rvalid,
    input  wire logic                                rready,
    output logic [31:0]                              rdata,
    output logic [1:0]                               rresp,
    input  wire logic                                in_lock,
    input  wire logic                                subcarrier_lock,
    input  wire logic                                field_rate_50hz,
    input  wire logic                                adc_underflow,
    input  wire logic                                adc_overflow,
    input  wire logic                                white_peak_active,
    input  wire logic                                color_kill_active,
    input  wire logic                                timing_output_disable,
    input  wire logic                                clamp_start,
    input  wire logic                                powerdown_pin_n,
    input  wire logic                                reacquire_pin,
    input  wire logic                                output_enable_pin_n,
    output logic [1:0]                               power_save_select,
    output logic                                     full_operation,
    output logic                                     composite_only,
    output logic                                     digital_only,
    output logic                                     power_save_mode,
    output logic                                     core_powerdown,
    output logic                                     reference_sleep,
    output logic                                     line_clock_gen_sleep,
    output logic                                     input_pads_disable,
    output logic                                     ref_clock_stop,
    output logic                                     timing_reacquire,
    output logic                                     core_reset,
    output logic                                     sync_outputs_drive,
    output logic                                     current_clamp_on,
    output logic                                     voltage_clamp_on,
    output logic                                     slow_clamp_current,
    output logic                                     fast_clamp_current,
    output logic                                     irq
);
    import decoder_regs_pkg::*;

    typedef struct packed {
        logic              aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_full;
        logic [7:0]        w_data;
        logic              w_lane0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [7:0]        power;
        logic [7:0]        analog;
        logic [5:0]        clamp;
        logic              lost_lock;
        logic              lock_prev;
        logic              under_prev;
        logic              over_prev;
        logic [3:0]        irq_status;
        logic [3:0]        irq_mask;
        logic [7:0]        acc;
        logic [7:0]        slow_cnt;
        logic [7:0]        fast_cnt;
        logic              pd_s1;
        logic              pd_s2;
        logic              rq_s1;
        logic              rq_s2;
        logic              oe_s1;
        logic              oe_s2;
    } state_t;

    localparam state_t ST_RST = '{
        aw_full:    1'b0,
        aw_addr:    '0,
        w_full:     1'b0,
        w_data:     8'h00,
        w_lane0:    1'b0,
        bvalid:     1'b0,
        bresp:      RESP_OKAY,
        rvalid:     1'b0,
        rdata:      32'h0000_0000,
        rresp:      RESP_OKAY,
        power:      POWER_RST,
        analog:     ANALOG_RST,
        clamp:      CLAMP_RST,
        lost_lock:  1'b0,
        lock_prev:  1'b0,
        under_prev: 1'b0,
        over_prev:  1'b0,
        irq_status: 4'h0,
        irq_mask:   IRQ_MASK_RST,
        acc:        8'h00,
        slow_cnt:   8'h00,
        fast_cnt:   8'h00,
        pd_s1:      1'b1,
        pd_s2:      1'b1,
        rq_s1:      1'b0,
        rq_s2:      1'b0,
        oe_s1:      1'b1,
        oe_s2:      1'b1
    };

    state_t q_q;
    state_t q_d;

    logic [8:0] acc_sum;
    logic       tick;
    logic [3:0] events;
    logic [5:0] rd_idx;
    logic [5:0] wr_idx;
    logic       wr_commit;
    logic [7:0] status_val;

    // Register index from a byte address; low two bits ignored
    function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] addr);
        reg_index = 6'(addr >> 2);
    endfunction

    function automatic logic is_mapped(input logic [5:0] idx);
        is_mapped = (idx == IDX_POWER) || (idx == IDX_STATUS) || (idx == IDX_REVISION)
                 || (idx == IDX_ANALOG) || (idx == IDX_CLAMP) || (idx == IDX_IRQ_STAT)
                 || (idx == IDX_IRQ_MASK);
    endfunction

    // Clamp on-time in reference cycles: 16 shifted left by the code
    function automatic logic [7:0] clamp_len(input logic [1:0] code);
        clamp_len = 8'(CLAMP_BASE << code);
    endfunction

    always_comb
    begin
        q_d = q_q;

        // Fractional divider: one-cycle enable at the reference clock rate
        acc_sum = {1'b0, q_q.acc} + REF_STEP;
        tick    = (acc_sum >= ACC_MOD);
        q_d.acc = tick ? 8'(acc_sum - ACC_MOD) : acc_sum[7:0];

        // Pins from outside the clock domain pass two flip-flops first
        q_d.pd_s1 = powerdown_pin_n;
        q_d.pd_s2 = q_q.pd_s1;
        q_d.rq_s1 = reacquire_pin;
        q_d.rq_s2 = q_q.rq_s1;
        q_d.oe_s1 = output_enable_pin_n;
        q_d.oe_s2 = q_q.oe_s1;

        // Edge detection on core status levels
        q_d.lock_prev  = in_lock;
        q_d.under_prev = adc_underflow;
        q_d.over_prev  = adc_overflow;
        events            = 4'h0;
        events[IRQ_LOST]  = q_q.lock_prev & ~in_lock;
        events[IRQ_GAIN]  = ~q_q.lock_prev & in_lock;
        events[IRQ_UNDER] = ~q_q.under_prev & adc_underflow;
        events[IRQ_OVER]  = ~q_q.over_prev & adc_overflow;

        status_val            = 8'h00;
        status_val[ST_LOCK]   = in_lock;
        status_val[ST_LOST]   = q_q.lost_lock;
        status_val[ST_FSC]    = subcarrier_lock;
        status_val[ST_50HZ]   = field_rate_50hz;
        status_val[ST_UNDER]  = adc_underflow;
        status_val[ST_OVER]   = adc_overflow;
        status_val[ST_WHITE]  = white_peak_active;
        status_val[ST_KILL]   = color_kill_active;

        // Write address and data are taken independently, in either order
        if (awvalid && !q_q.aw_full && !q_q.bvalid)
        begin
            q_d.aw_full = 1'b1;
            q_d.aw_addr = awaddr;
        end
        if (wvalid && !q_q.w_full && !q_q.bvalid)
        begin
            q_d.w_full  = 1'b1;
            q_d.w_data  = wdata[7:0];
            q_d.w_lane0 = wstrb[0];
        end
        if (q_q.bvalid && bready)
        begin
            q_d.bvalid = 1'b0;
        end

        // Reacquire clears on the next reference tick; a fresh write may set it again
        if (tick && q_q.power[PWR_REACQ])
        begin
            q_d.power[PWR_REACQ] = 1'b0;
        end

        // Hardware set wins over software clear on the same cycle
        q_d.irq_status = q_q.irq_status | events;
        if (events[IRQ_LOST])
        begin
            q_d.lost_lock = 1'b1;
        end

        wr_idx    = reg_index(q_q.aw_addr);
        wr_commit = q_q.aw_full && q_q.w_full && !q_q.bvalid;
        if (wr_commit)
        begin
            q_d.aw_full = 1'b0;
            q_d.w_full  = 1'b0;
            q_d.bvalid  = 1'b1;
            q_d.bresp   = is_mapped(wr_idx) ? RESP_OKAY : RESP_DECERR;
            if (q_q.w_lane0)
            begin
                case (wr_idx)
                    IDX_POWER:
                    begin
                        q_d.power = q_q.w_data;
                        if (!q_q.w_data[PWR_REACQ])
                        begin
                            q_d.power[PWR_REACQ] = q_d.power[PWR_REACQ] & ~tick;
                        end
                    end
                    IDX_ANALOG:   q_d.analog = q_q.w_data;
                    IDX_CLAMP:    q_d.clamp  = q_q.w_data[5:0];
                    IDX_IRQ_STAT: q_d.irq_status = (q_q.irq_status & ~q_q.w_data[3:0]) | events;
                    IDX_IRQ_MASK: q_d.irq_mask = q_q.w_data[3:0];
                    default:      q_d.bresp = q_d.bresp;
                endcase
            end
        end

        // Read: data sampled at the address handshake and held until taken
        rd_idx = reg_index(araddr);
        if (q_q.rvalid && rready)
        begin
            q_d.rvalid = 1'b0;
        end
        if (arvalid && !q_q.rvalid)
        begin
            q_d.rvalid = 1'b1;
            q_d.rresp  = is_mapped(rd_idx) ? RESP_OKAY : RESP_DECERR;
            case (rd_idx)
                IDX_POWER:    q_d.rdata = {24'h00_0000, q_q.power};
                IDX_STATUS:
                begin
                    q_d.rdata = {24'h00_0000, status_val};
                    q_d.lost_lock = events[IRQ_LOST];
                end
                IDX_REVISION: q_d.rdata = {24'h00_0000, REVISION};
                IDX_ANALOG:   q_d.rdata = {24'h00_0000, q_q.analog};
                IDX_CLAMP:    q_d.rdata = {26'h000_0000, q_q.clamp};
                IDX_IRQ_STAT: q_d.rdata = {28'h000_0000, q_q.irq_status};
                IDX_IRQ_MASK: q_d.rdata = {28'h000_0000, q_q.irq_mask};
                default:      q_d.rdata = 32'h0000_0000;
            endcase
        end

        // Clamp timers count reference ticks; a new start restarts both
        if (clamp_start)
        begin
            q_d.slow_cnt = clamp_len(q_q.clamp[CL_SLOW_LSB +: 2]);
            q_d.fast_cnt = clamp_len(q_q.clamp[CL_FAST_LSB +: 2]);
        end
        else if (tick)
        begin
            if (q_q.slow_cnt != 8'h00)
            begin
                q_d.slow_cnt = q_q.slow_cnt - 8'h01;
            end
            if (q_q.fast_cnt != 8'h00)
            begin
                q_d.fast_cnt = q_q.fast_cnt - 8'h01;
            end
        end

        // Soft reset one cycle after the write; bus handshake state is kept
        // so the write that asked for it still completes
        if (q_q.power[PWR_RESET])
        begin
            q_d.power      = ST_RST.power;
            q_d.analog     = ST_RST.analog;
            q_d.clamp      = ST_RST.clamp;
            q_d.lost_lock  = ST_RST.lost_lock;
            q_d.irq_status = ST_RST.irq_status;
            q_d.irq_mask   = ST_RST.irq_mask;
            q_d.slow_cnt   = ST_RST.slow_cnt;
            q_d.fast_cnt   = ST_RST.fast_cnt;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q_q <= ST_RST;
        end
        else
        begin
            q_q <= q_d;
        end
    end

    // Bus handshake outputs
    assign awready = !q_q.aw_full && !q_q.bvalid;
    assign wready  = !q_q.w_full && !q_q.bvalid;
    assign bvalid  = q_q.bvalid;
    assign bresp   = q_q.bresp;
    assign arready = !q_q.rvalid;
    assign rvalid  = q_q.rvalid;
    assign rdata   = q_q.rdata;
    assign rresp   = q_q.rresp;

    // Power control
    assign power_save_select    = q_q.power[PWR_SAVE_LSB +: 2];
    assign full_operation       = (power_save_select == SEL_FULL);
    assign composite_only       = (power_save_select == SEL_COMPOSITE);
    assign digital_only         = (power_save_select == SEL_DIGITAL);
    assign power_save_mode      = (power_save_select == SEL_SAVE);
    assign core_powerdown       = q_q.power[PWR_PRIO] ? q_q.power[PWR_OFF]
                                                      : !q_q.pd_s2;
    assign reference_sleep      = q_q.power[PWR_REF];
    assign line_clock_gen_sleep = q_q.power[PWR_CG];
    assign input_pads_disable   = q_q.power[PWR_OFF];
    assign ref_clock_stop       = q_q.power[PWR_OFF];
    assign timing_reacquire     = q_q.power[PWR_REACQ] | q_q.rq_s2;
    assign core_reset           = q_q.power[PWR_RESET];

    // Sync drivers: forced on, else OE pin low and output disable clear
    assign sync_outputs_drive   = q_q.analog[AN_FORCE]
                                | (!q_q.oe_s2 && !timing_output_disable);

    // Clamp controls
    assign current_clamp_on     = q_q.clamp[CL_CURR];
    assign voltage_clamp_on     = q_q.clamp[CL_VOLT];
    assign slow_clamp_current   = current_clamp_on && (q_q.slow_cnt != 8'h00);
    assign fast_clamp_current   = current_clamp_on && (q_q.fast_cnt != 8'h00);

    assign irq = |(q_q.irq_status & q_q.irq_mask);

endmodule

/* File: sim/decoder_regs_checker.sv */
// Port-level assertions for the decoder power, status and clamp register bank
`timescale 1ns/1ps
module decoder_regs_checker (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       reacquire_pin,
    input wire logic       timing_reacquire,
    input wire logic       core_reset,
    input wire logic [1:0] power_save_select,
    input wire logic       full_operation,
    input wire logic       composite_only,
    input wire logic       digital_only,
    input wire logic       power_save_mode,
    input wire logic       current_clamp_on,
    input wire logic       voltage_clamp_on,
    input wire logic       slow_clamp_current,
    input wire logic       fast_clamp_current,
    input wire logic       clamp_start,
    input wire logic       output_enable_pin_n,
    input wire logic       timing_output_disable,
    input wire logic       sync_outputs_drive
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_mode_decode: assert property (
        {full_operation, composite_only, digital_only, power_save_mode}
            == (4'h8 >> power_save_select)) else $error("power mode decode wrong");
    // Pin quiet for four cycles so only the register bit can hold the level
    a_reacq_clears: assert property (
        (!reacquire_pin)[*4] ##0 timing_reacquire |-> ##[1:9] !timing_reacquire)
        else $error("reacquire did not clear");
    a_reset_pulse: assert property ($rose(core_reset) |=> !core_reset)
        else $error("core reset longer than one cycle");
    a_reset_clears: assert property (
        core_reset |=> power_save_select == 2'h0 && !current_clamp_on && !voltage_clamp_on)
        else $error("soft reset left settings");
    a_clamp_gated: assert property (
        slow_clamp_current || fast_clamp_current |-> current_clamp_on)
        else $error("clamp current without enable");
    a_sync_drive: assert property (
        (!output_enable_pin_n)[*4] ##0 !timing_output_disable |-> sync_outputs_drive)
        else $error("sync drivers not active");
    a_clamp_hold: assert property (
        clamp_start && current_clamp_on |=> (slow_clamp_current && fast_clamp_current)[*8])
        else $error("clamp currents ended early");
    a_fast_bound: assert property (
        $rose(fast_clamp_current) |-> ##[1:960] !fast_clamp_current)
        else $error("fast clamp current too long");
endmodule

bind decoder_power_status_clamp_regs decoder_regs_checker chk_i (.*);

/* File: sim/host_axi_model.sv */
// Host-side AXI4-Lite master that programs the register bank
`timescale 1ns/1ps
module host_axi_model (
    input  wire logic        aclk,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [7:0]       awaddr,
    output logic             wvalid,
    input  wire logic        wready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    input  wire logic        bvalid,
    output logic             bready,
    input  wire logic [1:0]  bresp,
    output logic             arvalid,
    input  wire logic        arready,
    output logic [7:0]       araddr,
    input  wire logic        rvalid,
    output logic             rready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp
);
    int timeouts;
    // Responses are always accepted, so the slave never waits on the host
    assign bready = 1'b1;
    assign rready = 1'b1;
    initial
    begin
        {awvalid, wvalid, arvalid, wstrb, awaddr, araddr} = 23'h0f_0000;
        wdata = 32'h0000_0000;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] rs);
        int n;
        n = 0;
        {awvalid, wvalid} <= 2'h3;
        awaddr <= a;
        wdata <= dt;
        do
        begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        while (!bvalid && n < 100);
        rs = bresp;
        if (n >= 100) timeouts++;
        if (n >= 100) tb_decoder_power_status_clamp_regs.test_done();
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
        int n;
        n = 0;
        arvalid <= 1'b1;
        araddr <= a;
        do
        begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end
        while (!rvalid && n < 100);
        dt = rdata;
        rs = rresp;
        if (n >= 100) timeouts++;
        if (n >= 100) tb_decoder_power_status_clamp_regs.test_done();
    endtask
endmodule

/* File: sim/tb_decoder_power_status_clamp_regs.sv */
// Self-checking bench for the decoder power, status and clamp register bank
`timescale 1ns/1ps
module tb_decoder_power_status_clamp_regs;
    import decoder_regs_pkg::*;
    localparam logic [7:0] REV = 8'h5c; // Arbitrary value
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
    logic        arready, rvalid, rready, in_lock, subcarrier_lock, field_rate_50hz;
    logic        adc_underflow, adc_overflow, white_peak_active, color_kill_active, irq;
    logic        timing_output_disable, clamp_start, powerdown_pin_n, reacquire_pin;
    logic        output_enable_pin_n, full_operation, composite_only, digital_only;
    logic        power_save_mode, core_powerdown, reference_sleep, line_clock_gen_sleep;
    logic        input_pads_disable, ref_clock_stop, timing_reacquire, core_reset;
    logic        sync_outputs_drive, current_clamp_on, voltage_clamp_on;
    logic        slow_clamp_current, fast_clamp_current;
    logic [7:0]  awaddr, araddr, v;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, power_save_select, r;
    int          fail_count, num_checks, seed, rq_n, rs_n, b, sl, fs, k;

    decoder_power_status_clamp_regs #(.REVISION(REV)) dut (.*);
    host_axi_model host (.*);

    initial aclk = 1'b0;
    always #2.5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        rq_n <= rq_n + int'(timing_reacquire);
        rs_n <= rs_n + int'(core_reset);
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [5:0] i, input logic [7:0] e);
        host.rd({i, 2'b00}, d, r);
        chk(d, {24'h00_0000, e});
        chk(r, RESP_OKAY);
    endtask
    task automatic wreg(input logic [5:0] i, input logic [7:0] e);
        host.wr({i, 2'b00}, {24'h00_0000, e}, r);
        chk(r, RESP_OKAY);
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Timers run on reference ticks, so the length in system cycles is scaled
    function automatic int ncyc(input int c);
        return (16 << c) * CLK_FREQ_KHZ / REF_FREQ_KHZ;
    endfunction
    task automatic test_done;
        fail_count += host.timeouts;
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        seed = 25;
        aresetn = 1'b0;
        {in_lock, subcarrier_lock, field_rate_50hz, adc_underflow, adc_overflow} = 5'h00;
        {white_peak_active, color_kill_active, timing_output_disable, clamp_start} = 4'h0;
        {powerdown_pin_n, reacquire_pin, output_enable_pin_n} = 3'h5;
        ticks(20);
        aresetn <= 1'b1;
        ticks(1);
        rchk(IDX_POWER, POWER_RST);
        rchk(IDX_ANALOG, ANALOG_RST);
        rchk(IDX_CLAMP, {2'b00, CLAMP_RST});
        host.wr({IDX_REVISION, 2'b00}, 32'h0000_0000, r);
        rchk(IDX_REVISION, REV);
        host.rd(8'h48, d, r);
        chk(r, RESP_DECERR);
        for (int i = 0; i < 4; i++)
        begin
            v = (8'($random(seed)) & 8'h3c) | 8'(i);
            wreg(IDX_POWER, v);
            chk({full_operation, composite_only, digital_only, power_save_mode}, 4'h8 >> i);
            chk({line_clock_gen_sleep, reference_sleep}, v[4:3]);
            chk({input_pads_disable, ref_clock_stop}, {2{v[5]}});
            chk(core_powerdown, v[2] & v[5]);
            rchk(IDX_POWER, v);
        end
        wreg(IDX_POWER, 8'h20);
        powerdown_pin_n <= 1'b0;
        ticks(4);
        chk(core_powerdown, 1'b1);
        powerdown_pin_n <= 1'b1;
        b = rq_n;
        wreg(IDX_POWER, 8'h40);
        ticks(10);
        chk((rq_n - b) inside {[1:8]}, 1'b1);
        rchk(IDX_POWER, 8'h00);
        b = rq_n;
        reacquire_pin <= 1'b1;
        ticks(2);
        reacquire_pin <= 1'b0;
        ticks(6);
        chk(rq_n - b, 2);
        wreg(IDX_ANALOG, ANALOG_RST | 8'h02);
        chk(sync_outputs_drive, 1'b1);
        wreg(IDX_CLAMP, 8'h3f);
        b = rs_n;
        wreg(IDX_POWER, 8'h80);
        ticks(2);
        chk(rs_n - b, 1);
        chk(sync_outputs_drive, 1'b0);
        rchk(IDX_ANALOG, ANALOG_RST);
        rchk(IDX_CLAMP, 8'h00);
        output_enable_pin_n <= 1'b0;
        ticks(4);
        chk(sync_outputs_drive, 1'b1);
        timing_output_disable <= 1'b1;
        ticks(1);
        chk(sync_outputs_drive, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            v = (8'($random(seed)) & 8'hfc) | {6'h00, i[0], 1'b1};
            {color_kill_active, white_peak_active, adc_overflow, adc_underflow} <= v[7:4];
            {field_rate_50hz, subcarrier_lock, in_lock} <= {v[3:2], 1'b1};
            host.rd({IDX_STATUS, 2'b00}, d, r);
            in_lock <= !v[1];
            ticks(1);
            in_lock <= 1'b1;
            ticks(1);
            rchk(IDX_STATUS, v);
            rchk(IDX_STATUS, v & 8'hfd);
        end
        wreg(IDX_IRQ_STAT, 8'h0f);
        wreg(IDX_IRQ_MASK, 8'h01);
        in_lock <= 1'b0;
        ticks(3);
        chk(irq, 1'b1);
        in_lock <= 1'b1;
        wreg(IDX_IRQ_STAT, 8'h01);
        chk(irq, 1'b0);
        rchk(IDX_IRQ_STAT, 8'h02);
        for (int c = 0; c < 4; c++)
        begin
            wreg(IDX_CLAMP, {2'b00, c[0], 1'b1, 2'(3 - c), c[1:0]});
            chk({voltage_clamp_on, current_clamp_on}, {c[0], 1'b1});
            clamp_start <= 1'b1;
            ticks(1);
            clamp_start <= 1'b0;
            {sl, fs, k} = {32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
            do
            begin
                ticks(1);
                sl += int'(slow_clamp_current);
                fs += int'(fast_clamp_current);
                k++;
            end
            while ((slow_clamp_current || fast_clamp_current) && k < 1100);
            chk(sl inside {[ncyc(c) - 9 : ncyc(c) + 9]}, 1'b1);
            chk(fs inside {[ncyc(3 - c) - 9 : ncyc(3 - c) + 9]}, 1'b1);
        end
        wreg(IDX_CLAMP, 8'h0f);
        clamp_start <= 1'b1;
        ticks(1);
        clamp_start <= 1'b0;
        ticks(2);
        chk({slow_clamp_current, fast_clamp_current}, 2'b00);
        test_done();
    end
endmodule
